/* File: logic/qpq_params.svh */
// Offsets, field positions and reset values of the QoS priority/queue register bank
`ifndef QPQ_PARAMS_SVH
`define QPQ_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define QPQ_WRED_COLOR_CODEPOINT_MAP 16'h0378
`define QPQ_PTP_EVENT_PRIORITY_CTRL 16'h037C
`define QPQ_PTP_NONEVENT_PRIORITY_CTRL 16'h037D
`define QPQ_QUEUE_MANAGEMENT_CTRL 16'h0390

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define QPQ_RED_HI 5
`define QPQ_RED_LO 4
`define QPQ_YELLOW_HI 3
`define QPQ_YELLOW_LO 2
`define QPQ_GREEN_HI 1
`define QPQ_GREEN_LO 0
`define QPQ_OVERRIDE_BIT 7
`define QPQ_PRIO_HI 3
`define QPQ_PRIO_LO 0
`define QPQ_MAP_HI 7
`define QPQ_MAP_LO 6
`define QPQ_RSVD_HI 5
`define QPQ_RSVD_LO 2
`define QPQ_DISCARD_BIT 1
`define QPQ_RSVD0_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define QPQ_RED_RST 2'h3
`define QPQ_YELLOW_RST 2'h2
`define QPQ_GREEN_RST 2'h1
`define QPQ_OVERRIDE_RST 1'h0
`define QPQ_PRIO_RST 4'hF
`define QPQ_MAP_RST 2'h2
`define QPQ_RSVD_RST 4'h0
`define QPQ_DISCARD_RST 1'h1
`define QPQ_RSVD0_RST 1'h0

`endif

/* File: logic/qpq_pkg.sv */
// Types shared by the QoS priority/queue register bank
package qpq_pkg;
    typedef logic [1:0] qpq_code_t;
    typedef logic [3:0] qpq_prio_t;
    typedef logic [6:0] qpq_ports_t;
    typedef logic [31:0] qpq_data_t;
    typedef logic [15:0] qpq_addr_t;
    // Two-queue split selector; 01 is an unused encoding
    typedef enum logic [1:0] {
        QPQ_MAP_TOP1 = 2'h0,
        QPQ_MAP_UNUSED = 2'h1,
        QPQ_MAP_TOP2 = 2'h2,
        QPQ_MAP_TOP3 = 2'h3
    } qpq_map_t;
    // Colour selector on the lookup port
    typedef enum logic [1:0] {
        QPQ_COL_GREEN = 2'h0,
        QPQ_COL_YELLOW = 2'h1,
        QPQ_COL_RED = 2'h2,
        QPQ_COL_NONE = 2'h3
    } qpq_color_t;
endpackage

/* File: logic/qpq_ptp_prio.sv */
// PTP message priority override stage
`timescale 1ns/1ps
`include "qpq_params.svh"
module qpq_ptp_prio (
    input wire logic clk, // Core clock
    input wire logic rst, // Async reset, high
    input wire logic pkt_valid, // Packet qualifier
    input wire logic is_event, // Packet is a PTP event message
    input wire logic is_nonevent, // Packet is a PTP non-event message
    input wire qpq_pkg::qpq_prio_t qos_prio, // Priority from normal QoS
    input wire logic evt_override, // Event override enable
    input wire qpq_pkg::qpq_prio_t evt_prio, // Forced event priority
    input wire logic nevt_override, // Non-event override enable
    input wire qpq_pkg::qpq_prio_t nevt_prio, // Forced non-event priority
    output logic prio_valid, // Result qualifier
    output qpq_pkg::qpq_prio_t prio, // Resulting priority
    output logic forced // Result came from an override
);
    wire force_evt;
    wire force_nevt;
    wire qpq_pkg::qpq_prio_t next_prio;

    // Event wins if a packet is flagged both ways; a frame cannot really be both
    assign force_evt = is_event && evt_override;
    assign force_nevt = !is_event && is_nonevent && nevt_override;
    assign next_prio = force_evt ? evt_prio :
                       force_nevt ? nevt_prio :
                       qos_prio;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prio_valid <= 1'h0;
            prio <= 4'h0;
            forced <= 1'h0;
        end else begin
            prio_valid <= pkt_valid;
            prio <= pkt_valid ? next_prio : 4'h0;
            forced <= pkt_valid && (force_evt || force_nevt);
        end
    end
endmodule

/* File: logic/qpq_fwd_ctrl.sv */
// Two-queue split and port membership forwarding stage
`timescale 1ns/1ps
module qpq_fwd_ctrl (
    input wire logic clk, // Core clock
    input wire logic rst, // Async reset, high
    input wire qpq_pkg::qpq_map_t map_sel, // Two-queue split selector
    input wire qpq_pkg::qpq_code_t regen_prio, // Regenerated 2-bit priority
    input wire logic frame_valid, // Frame qualifier
    input wire logic discard_en, // Confine every frame to membership
    input wire qpq_pkg::qpq_ports_t dest_ports, // Lookup destination ports
    input wire qpq_pkg::qpq_ports_t member_ports, // Per-port membership set
    input wire logic mirror_en, // Mirroring enabled
    input wire logic mirrored, // Frame is mirrored to another port
    output logic high_queue, // Priority goes to the high queue
    output logic fwd_valid, // Forwarding result qualifier
    output qpq_pkg::qpq_ports_t fwd_ports, // Resulting forwarding ports
    output logic frame_drop // Frame is dropped
);
    logic next_high;
    wire single_dest;
    wire mirror_drop;
    wire qpq_pkg::qpq_ports_t next_fwd;

    always_comb begin
        case (map_sel)
            qpq_pkg::QPQ_MAP_TOP1: next_high = (regen_prio == 2'h3);
            qpq_pkg::QPQ_MAP_TOP3: next_high = (regen_prio != 2'h0);
            // Unused code behaves as the reset split rather than hanging traffic
            default: next_high = regen_prio[1];
        endcase
    end

    assign single_dest = (dest_ports != 7'h00) && ((dest_ports & (dest_ports - 7'h01)) == 7'h00);
    assign mirror_drop = !discard_en && single_dest && mirror_en && mirrored;
    assign next_fwd = discard_en ? (dest_ports & member_ports) :
                      single_dest ? dest_ports :
                      (dest_ports & member_ports);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            high_queue <= 1'h0;
            fwd_valid <= 1'h0;
            fwd_ports <= 7'h00;
            frame_drop <= 1'h0;
        end else begin
            high_queue <= next_high;
            fwd_valid <= frame_valid;
            fwd_ports <= (frame_valid && !mirror_drop) ? next_fwd : 7'h00;
            frame_drop <= frame_valid && mirror_drop;
        end
    end
endmodule

/* File: logic/qpq_regs.sv */
// QoS priority and queue control register bank with its datapath stages
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "qpq_params.svh"

// Functional notes
// - Red, yellow and green code-point fields are 2 bits each and reset to 11b, 10b and 01b.
// - With the event override clear PTP event messages keep their QoS priority, else forced.
// - The 4-bit event priority in bits 3:0 resets to all ones and is used while forced.
// - With the non-event override clear non-event messages keep QoS priority, else forced.
// - The 4-bit non-event priority in bits 3:0 resets to all ones and is used while forced.
// - The two-queue selector sends 3 high for 00, 2-3 high for 10, 1-3 high for 11; reset 10.
// - With the membership discard bit set, its reset value, frames stay within membership.
// - With the discard bit clear, single-destination frames ignore the membership set.
// - With the discard bit clear and mirroring on, a mirrored single-destination frame drops.
module qpq_regs (
    input wire logic CLK, // Core clock, 125 MHz
    input wire logic RST, // Async reset, high
    input wire qpq_pkg::qpq_addr_t ADDR, // Register byte address
    input wire qpq_pkg::qpq_data_t WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output qpq_pkg::qpq_data_t RDATA, // Read data, cycle after RD
    input wire logic PKT_VALID, // Packet classification request
    input wire logic PTP_EVENT, // Packet is a PTP event message
    input wire logic PTP_NONEVENT, // Packet is a PTP non-event message
    input wire qpq_pkg::qpq_prio_t QOS_PRIO, // Priority from normal QoS
    output logic PRIO_VALID, // Priority result qualifier
    output qpq_pkg::qpq_prio_t PKT_PRIO, // Queuing priority
    output logic PRIO_FORCED, // Priority came from an override
    input wire qpq_pkg::qpq_code_t REGEN_PRIO, // Regenerated 2-bit priority
    output logic HIGH_QUEUE, // High queue select
    input wire logic FRAME_VALID, // Forwarding request
    input wire qpq_pkg::qpq_ports_t DEST_PORTS, // Lookup destination ports
    input wire qpq_pkg::qpq_ports_t MEMBER_PORTS, // Per-port membership set
    input wire logic MIRROR_EN, // Mirroring enabled
    input wire logic MIRRORED, // Frame mirrored to another port
    output logic FWD_VALID, // Forwarding result qualifier
    output qpq_pkg::qpq_ports_t FWD_PORTS, // Resulting forwarding ports
    output logic FRAME_DROP, // Frame dropped
    input wire qpq_pkg::qpq_color_t COLOR_SEL, // Colour to look up
    output qpq_pkg::qpq_code_t COLOR_CODEPOINT, // Code point of that colour
    output qpq_pkg::qpq_code_t RED_CODEPOINT, // Red code point
    output qpq_pkg::qpq_code_t YELLOW_CODEPOINT, // Yellow code point
    output qpq_pkg::qpq_code_t GREEN_CODEPOINT // Green code point
);
    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    qpq_pkg::qpq_code_t red_cp;
    qpq_pkg::qpq_code_t yellow_cp;
    qpq_pkg::qpq_code_t green_cp;
    logic evt_override;
    qpq_pkg::qpq_prio_t evt_prio;
    logic nevt_override;
    qpq_pkg::qpq_prio_t nevt_prio;
    qpq_pkg::qpq_map_t two_queue_priority_map;
    logic [3:0] qm_spare;
    logic discard_en;
    logic qm_spare0;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire hit_wred;
    wire hit_evt;
    wire hit_nevt;
    wire hit_qm;
    wire wr_wred;
    wire wr_evt;
    wire wr_nevt;
    wire wr_qm;

    assign hit_wred = (ADDR == `QPQ_WRED_COLOR_CODEPOINT_MAP);
    assign hit_evt = (ADDR == `QPQ_PTP_EVENT_PRIORITY_CTRL);
    assign hit_nevt = (ADDR == `QPQ_PTP_NONEVENT_PRIORITY_CTRL);
    assign hit_qm = (ADDR == `QPQ_QUEUE_MANAGEMENT_CTRL);
    assign wr_wred = WR && hit_wred;
    assign wr_evt = WR && hit_evt;
    assign wr_nevt = WR && hit_nevt;
    assign wr_qm = WR && hit_qm;

    // ----------------------------------------------------------------
    // Colour code-point map
    // ----------------------------------------------------------------
    // Bits 7:6 are not stored, so writes there fall away
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            red_cp <= `QPQ_RED_RST;
            yellow_cp <= `QPQ_YELLOW_RST;
            green_cp <= `QPQ_GREEN_RST;
        end else if (wr_wred) begin
            red_cp <= WDATA[`QPQ_RED_HI:`QPQ_RED_LO];
            yellow_cp <= WDATA[`QPQ_YELLOW_HI:`QPQ_YELLOW_LO];
            green_cp <= WDATA[`QPQ_GREEN_HI:`QPQ_GREEN_LO];
        end
    end

    // ----------------------------------------------------------------
    // PTP event and non-event priority controls
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            evt_override <= `QPQ_OVERRIDE_RST;
            evt_prio <= `QPQ_PRIO_RST;
        end else if (wr_evt) begin
            evt_override <= WDATA[`QPQ_OVERRIDE_BIT];
            evt_prio <= WDATA[`QPQ_PRIO_HI:`QPQ_PRIO_LO];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            nevt_override <= `QPQ_OVERRIDE_RST;
            nevt_prio <= `QPQ_PRIO_RST;
        end else if (wr_nevt) begin
            nevt_override <= WDATA[`QPQ_OVERRIDE_BIT];
            nevt_prio <= WDATA[`QPQ_PRIO_HI:`QPQ_PRIO_LO];
        end
    end

    // ----------------------------------------------------------------
    // Queue management control
    // ----------------------------------------------------------------
    // The spare fields are writable storage; only bits 31:8 are read-only zero
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            two_queue_priority_map <= qpq_pkg::qpq_map_t'(`QPQ_MAP_RST);
            qm_spare <= `QPQ_RSVD_RST;
            discard_en <= `QPQ_DISCARD_RST;
            qm_spare0 <= `QPQ_RSVD0_RST;
        end else if (wr_qm) begin
            two_queue_priority_map <= qpq_pkg::qpq_map_t'(WDATA[`QPQ_MAP_HI:`QPQ_MAP_LO]);
            qm_spare <= WDATA[`QPQ_RSVD_HI:`QPQ_RSVD_LO];
            discard_en <= WDATA[`QPQ_DISCARD_BIT];
            qm_spare0 <= WDATA[`QPQ_RSVD0_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Read-back
    // ----------------------------------------------------------------
    wire qpq_pkg::qpq_data_t rd_wred;
    wire qpq_pkg::qpq_data_t rd_evt;
    wire qpq_pkg::qpq_data_t rd_nevt;
    wire qpq_pkg::qpq_data_t rd_qm;
    wire qpq_pkg::qpq_data_t next_rdata;

    assign rd_wred = {26'h0000000, red_cp, yellow_cp, green_cp};
    assign rd_evt = {24'h000000, evt_override, 3'h0, evt_prio};
    assign rd_nevt = {24'h000000, nevt_override, 3'h0, nevt_prio};
    assign rd_qm = {24'h000000, two_queue_priority_map, qm_spare, discard_en, qm_spare0};
    // Unmapped addresses read as zero
    assign next_rdata = !RD ? 32'h00000000 :
                        hit_wred ? rd_wred :
                        hit_evt ? rd_evt :
                        hit_nevt ? rd_nevt :
                        hit_qm ? rd_qm :
                        32'h00000000;

    // Data stand for exactly one cycle so a stale word is never mistaken for a read
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 32'h00000000;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Colour lookup and code-point outputs
    // ----------------------------------------------------------------
    qpq_pkg::qpq_code_t next_color_cp;

    always_comb begin
        case (COLOR_SEL)
            qpq_pkg::QPQ_COL_GREEN: next_color_cp = green_cp;
            qpq_pkg::QPQ_COL_YELLOW: next_color_cp = yellow_cp;
            qpq_pkg::QPQ_COL_RED: next_color_cp = red_cp;
            default: next_color_cp = 2'h0;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            COLOR_CODEPOINT <= 2'h0;
            RED_CODEPOINT <= `QPQ_RED_RST;
            YELLOW_CODEPOINT <= `QPQ_YELLOW_RST;
            GREEN_CODEPOINT <= `QPQ_GREEN_RST;
        end else begin
            COLOR_CODEPOINT <= next_color_cp;
            RED_CODEPOINT <= red_cp;
            YELLOW_CODEPOINT <= yellow_cp;
            GREEN_CODEPOINT <= green_cp;
        end
    end

    // ----------------------------------------------------------------
    // PTP priority stage
    // ----------------------------------------------------------------
    qpq_ptp_prio u_ptp_prio (
        .clk(CLK),
        .rst(RST),
        .pkt_valid(PKT_VALID),
        .is_event(PTP_EVENT),
        .is_nonevent(PTP_NONEVENT),
        .qos_prio(QOS_PRIO),
        .evt_override(evt_override),
        .evt_prio(evt_prio),
        .nevt_override(nevt_override),
        .nevt_prio(nevt_prio),
        .prio_valid(PRIO_VALID),
        .prio(PKT_PRIO),
        .forced(PRIO_FORCED)
    );

    // ----------------------------------------------------------------
    // Queue split and forwarding stage
    // ----------------------------------------------------------------
    qpq_fwd_ctrl u_fwd_ctrl (
        .clk(CLK),
        .rst(RST),
        .map_sel(two_queue_priority_map),
        .regen_prio(REGEN_PRIO),
        .frame_valid(FRAME_VALID),
        .discard_en(discard_en),
        .dest_ports(DEST_PORTS),
        .member_ports(MEMBER_PORTS),
        .mirror_en(MIRROR_EN),
        .mirrored(MIRRORED),
        .high_queue(HIGH_QUEUE),
        .fwd_valid(FWD_VALID),
        .fwd_ports(FWD_PORTS),
        .frame_drop(FRAME_DROP)
    );
endmodule

/* File: sim/qpq_regs_chk.sv */
// Concurrent port checks for the QoS priority/queue register bank
`timescale 1ns/1ps
`include "qpq_params.svh"
module qpq_regs_chk (
    input wire logic CLK, // Core clock
    input wire logic RST, // Async reset, high
    input wire qpq_pkg::qpq_addr_t ADDR, // Register byte address
    input wire qpq_pkg::qpq_data_t WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    input wire qpq_pkg::qpq_data_t RDATA, // Read data
    input wire logic PKT_VALID, // Packet request
    input wire logic PTP_EVENT, // Event message flag
    input wire logic PTP_NONEVENT, // Non-event message flag
    input wire qpq_pkg::qpq_prio_t QOS_PRIO, // Normal QoS priority
    input wire logic PRIO_VALID, // Priority result qualifier
    input wire qpq_pkg::qpq_prio_t PKT_PRIO, // Queuing priority
    input wire logic PRIO_FORCED, // Override picked the priority
    input wire qpq_pkg::qpq_code_t REGEN_PRIO, // Regenerated priority
    input wire logic HIGH_QUEUE, // High queue select
    input wire logic FRAME_VALID, // Forwarding request
    input wire qpq_pkg::qpq_ports_t DEST_PORTS, // Destination ports
    input wire qpq_pkg::qpq_ports_t MEMBER_PORTS, // Membership set
    input wire logic MIRROR_EN, // Mirroring enabled
    input wire logic MIRRORED, // Frame mirrored
    input wire logic FWD_VALID, // Forwarding result qualifier
    input wire qpq_pkg::qpq_ports_t FWD_PORTS, // Forwarding ports
    input wire logic FRAME_DROP // Frame dropped
);
    // ----------------------------------------------------------------
    // Shadow of the control fields, rebuilt from the write traffic
    // ----------------------------------------------------------------
    logic [7:0] evt_s;
    logic [7:0] nevt_s;
    logic [1:0] map_s;
    logic disc_s;
    logic hq_exp;
    logic single;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            evt_s <= 8'h0F;
            nevt_s <= 8'h0F;
            map_s <= 2'h2;
            disc_s <= 1'h1;
        end else if (WR) begin
            if (ADDR == `QPQ_PTP_EVENT_PRIORITY_CTRL) evt_s <= WDATA[7:0] & 8'h8F;
            if (ADDR == `QPQ_PTP_NONEVENT_PRIORITY_CTRL) nevt_s <= WDATA[7:0] & 8'h8F;
            if (ADDR == `QPQ_QUEUE_MANAGEMENT_CTRL) map_s <= WDATA[7:6];
            if (ADDR == `QPQ_QUEUE_MANAGEMENT_CTRL) disc_s <= WDATA[1];
        end
    end
    // Unused code 01 is treated like 10, as the designer chose
    assign hq_exp = (map_s == 2'h0) ? (REGEN_PRIO == 2'h3) :
        (map_s == 2'h3) ? (REGEN_PRIO != 2'h0) : REGEN_PRIO[1];
    assign single = (DEST_PORTS != 7'h00) && ((DEST_PORTS & (DEST_PORTS - 7'h01)) == 7'h00);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    chk_evt_readback: assert property (RD && ADDR == `QPQ_PTP_EVENT_PRIORITY_CTRL
        |=> RDATA == {24'h0, evt_s}) else $error("event priority register reads wrong");
    chk_qm_readback: assert property (RD && ADDR == `QPQ_QUEUE_MANAGEMENT_CTRL
        |=> RDATA[31:8] == 24'h0 && RDATA[7:6] == map_s && RDATA[1] == disc_s)
        else $error("queue control register reads wrong");
    chk_evt_forced: assert property (PKT_VALID && PTP_EVENT && evt_s[7]
        |=> PRIO_VALID && PRIO_FORCED && PKT_PRIO == $past(evt_s[3:0]))
        else $error("event message not forced to its priority");
    chk_qos_kept: assert property (PKT_VALID && !(PTP_EVENT && evt_s[7])
        && !(PTP_NONEVENT && nevt_s[7]) |=> PRIO_VALID && !PRIO_FORCED
        && PKT_PRIO == $past(QOS_PRIO)) else $error("QoS priority not kept");
    chk_nevt_forced: assert property (PKT_VALID && !PTP_EVENT && PTP_NONEVENT
        && nevt_s[7] |=> PRIO_FORCED && PKT_PRIO == $past(nevt_s[3:0]))
        else $error("non-event message not forced to its priority");
    chk_queue_split: assert property (1'b1 |=> HIGH_QUEUE == $past(hq_exp))
        else $error("high queue select wrong for selector");
    chk_member_confine: assert property (FRAME_VALID && disc_s
        |=> FWD_VALID && !FRAME_DROP && FWD_PORTS == $past(DEST_PORTS & MEMBER_PORTS))
        else $error("frame not confined to membership");
    chk_single_free: assert property (FRAME_VALID && !disc_s && single
        && !(MIRROR_EN && MIRRORED) |=> FWD_VALID && FWD_PORTS == $past(DEST_PORTS))
        else $error("single destination frame was limited");
    chk_mirror_drop: assert property (FRAME_VALID && !disc_s && single && MIRROR_EN
        && MIRRORED |=> FRAME_DROP && FWD_PORTS == 7'h00)
        else $error("mirrored single destination frame not dropped");
endmodule
bind qpq_regs qpq_regs_chk qpq_regs_chk_inst (.*);

/* File: sim/qpq_regs_tb.sv */
// Self-checking bench for the QoS priority/queue register bank
`timescale 1ns/1ps
`include "qpq_params.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end
module qpq_regs_tb;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pkt_valid = 1'b0, ptp_event = 1'b0;
    logic ptp_nonevent = 1'b0, frame_valid = 1'b0, mirror_en = 1'b0, mirrored = 1'b0;
    qpq_pkg::qpq_addr_t addr = 16'h0000;
    qpq_pkg::qpq_data_t wdata = 32'h0, rdata;
    qpq_pkg::qpq_prio_t qos_prio = 4'h0, pkt_prio;
    qpq_pkg::qpq_code_t regen_prio = 2'h0, color_cp, red_cp, yellow_cp, green_cp;
    qpq_pkg::qpq_ports_t dest_ports = 7'h00, member_ports = 7'h00, fwd_ports;
    qpq_pkg::qpq_color_t color_sel = qpq_pkg::QPQ_COL_RED;
    logic prio_valid, prio_forced, high_queue, fwd_valid, frame_drop;
    logic [1:0] codes [3] = '{2'h0, 2'h2, 2'h3};
    // Priorities sent high for each selector code above, bit n for priority n
    logic [3:0] hi_mask [3] = '{4'h8, 4'hC, 4'hE};
    int n_errors = 0;
    int samples_checked = 0;

    qpq_regs qpq_regs_inst (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .PKT_VALID(pkt_valid), .PTP_EVENT(ptp_event),
        .PTP_NONEVENT(ptp_nonevent), .QOS_PRIO(qos_prio), .PRIO_VALID(prio_valid),
        .PKT_PRIO(pkt_prio), .PRIO_FORCED(prio_forced), .REGEN_PRIO(regen_prio),
        .HIGH_QUEUE(high_queue), .FRAME_VALID(frame_valid), .DEST_PORTS(dest_ports),
        .MEMBER_PORTS(member_ports), .MIRROR_EN(mirror_en), .MIRRORED(mirrored),
        .FWD_VALID(fwd_valid), .FWD_PORTS(fwd_ports), .FRAME_DROP(frame_drop),
        .COLOR_SEL(color_sel), .COLOR_CODEPOINT(color_cp), .RED_CODEPOINT(red_cp),
        .YELLOW_CODEPOINT(yellow_cp), .GREEN_CODEPOINT(green_cp));

    always #4 clk = ~clk;

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic wr_reg(input qpq_pkg::qpq_addr_t a, input qpq_pkg::qpq_data_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd_reg(input qpq_pkg::qpq_addr_t a, input qpq_pkg::qpq_data_t e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    task automatic pkt(input logic ev, input logic ne, input qpq_pkg::qpq_prio_t q,
        input qpq_pkg::qpq_prio_t e, input logic f);
        @(posedge clk);
        pkt_valid <= 1'b1;
        ptp_event <= ev;
        ptp_nonevent <= ne;
        qos_prio <= q;
        @(posedge clk);
        pkt_valid <= 1'b0;
        #1;
        `CHK({prio_valid, prio_forced, pkt_prio}, {1'b1, f, e})
    endtask
    task automatic frm(input qpq_pkg::qpq_ports_t d, input qpq_pkg::qpq_ports_t m,
        input logic mir, input qpq_pkg::qpq_ports_t e, input logic drop);
        @(posedge clk);
        frame_valid <= 1'b1;
        dest_ports <= d;
        member_ports <= m;
        mirrored <= mir;
        @(posedge clk);
        frame_valid <= 1'b0;
        #1;
        `CHK({fwd_valid, frame_drop, fwd_ports}, {1'b1, drop, e})
    endtask
    task automatic complete_run;
        $display("Mismatches %0d, comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Guards against a hung sequence
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        complete_run;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`QPQ_WRED_COLOR_CODEPOINT_MAP, 32'h39);
        rd_reg(`QPQ_PTP_EVENT_PRIORITY_CTRL, 32'h0F);
        rd_reg(`QPQ_PTP_NONEVENT_PRIORITY_CTRL, 32'h0F);
        rd_reg(`QPQ_QUEUE_MANAGEMENT_CTRL, 32'h82);
        `CHK({color_cp, red_cp, yellow_cp, green_cp}, 8'hF9)
        wr_reg(16'h037E, 32'hFFFFFFFF);
        rd_reg(16'h037E, 32'h0);
        wr_reg(`QPQ_WRED_COLOR_CODEPOINT_MAP, 32'hFFFFFFC6);
        rd_reg(`QPQ_WRED_COLOR_CODEPOINT_MAP, 32'h06);
        `CHK({color_cp, red_cp, yellow_cp, green_cp}, 8'h06)
        // Walk the lookup through green, yellow, red and none
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            color_sel <= qpq_pkg::qpq_color_t'(c[1:0]);
            @(posedge clk);
            #1;
            `CHK(color_cp, (c == 0) ? 2'h2 : (c == 1) ? 2'h1 : 2'h0)
        end
        pkt(1'b1, 1'b0, 4'h5, 4'h5, 1'b0);
        pkt(1'b0, 1'b1, 4'h6, 4'h6, 1'b0);
        wr_reg(`QPQ_PTP_EVENT_PRIORITY_CTRL, 32'hFFFFFFF3);
        rd_reg(`QPQ_PTP_EVENT_PRIORITY_CTRL, 32'h83);
        pkt(1'b1, 1'b0, 4'h5, 4'h3, 1'b1);
        pkt(1'b0, 1'b1, 4'h6, 4'h6, 1'b0);
        wr_reg(`QPQ_PTP_NONEVENT_PRIORITY_CTRL, 32'h0000008A);
        rd_reg(`QPQ_PTP_NONEVENT_PRIORITY_CTRL, 32'h8A);
        pkt(1'b0, 1'b1, 4'h6, 4'hA, 1'b1);
        pkt(1'b0, 1'b0, 4'h9, 4'h9, 1'b0);
        pkt(1'b1, 1'b1, 4'h4, 4'h3, 1'b1);
        // Code 01 is never programmed here, since software must avoid it
        foreach (codes[i]) begin
            wr_reg(`QPQ_QUEUE_MANAGEMENT_CTRL, {24'h0, codes[i], 6'h02});
            for (int p = 0; p < 4; p++) begin
                @(posedge clk);
                regen_prio <= p[1:0];
                @(posedge clk);
                #1;
                `CHK(high_queue, hi_mask[i][p])
            end
        end
        frm(7'h04, 7'h01, 1'b0, 7'h00, 1'b0);
        frm(7'h06, 7'h02, 1'b0, 7'h02, 1'b0);
        @(posedge clk);
        mirror_en <= 1'b1;
        frm(7'h04, 7'h05, 1'b1, 7'h04, 1'b0);
        wr_reg(`QPQ_QUEUE_MANAGEMENT_CTRL, 32'hFFFFFFBD);
        rd_reg(`QPQ_QUEUE_MANAGEMENT_CTRL, 32'hBD);
        frm(7'h04, 7'h01, 1'b0, 7'h04, 1'b0);
        frm(7'h06, 7'h02, 1'b0, 7'h02, 1'b0);
        frm(7'h04, 7'h01, 1'b1, 7'h00, 1'b1);
        @(posedge clk);
        mirror_en <= 1'b0;
        frm(7'h04, 7'h01, 1'b1, 7'h04, 1'b0);
        complete_run;
    end
endmodule
